// [rtl/esp_device.sv]
// Functional notes
// - Latch clear waits for select to rise
// - Latch cleared by reset, clear, cycle end
// - Status read always allowed, repeats continuously
// - Master polls busy before new instruction
// - Cycle flag high only during write cycles
// - Latch flag low rejects all writes
// - Protect selects nonvolatile, refuse region writes
// - Lock high, protect low: hardware mode
// - Latch set needed before status write
// - Status write is opcode plus one byte
// - Status write keeps b6-b4,b1,b0; b6-b4 zero
// - Select must rise right after eighth bit
// - Select rise starts cycle, end clears latch
// - Old protection bits hold until cycle end
// - Lock low: pin level does not matter
// - Lock high, pin high: writes accepted
// - Hardware mode leaves only by pin high
// - Region writes refused in both modes
// - One-byte opcodes; unknown opcode deselects device
// - Selects: none, quarter, half, whole
// - Reset clears flags, needs select fall
// - MSB first, sample rise, drive fall
module esp_device #(
  parameter int CYCLE_LEN = esp_pkg::CYCLE_CLKS // Self-timed cycle in core clocks
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic nv_load, // Loads delivery state into nonvolatile bits
  esp_link_if.device link,
  input wire logic array_wr_req, // Array write request pulse
  input wire logic [esp_pkg::ADDR_W-1:0] array_wr_addr,
  output logic array_wr_ack, // Array write accepted, cycle started
  output logic array_wr_nak, // Array write refused
  output logic [7:0] protection_status,
  output logic hard_protect_mode,
  output logic soft_protect_mode
);
  import esp_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sel_m, sel_s, sel_d; // Select: meta, stable, delayed
  logic sclk_m, sclk_s, sclk_d; // Link clock: meta, stable, delayed
  logic mosi_m, mosi_s; // Data in
  logic wp_m, wp_s; // Write protect pin

  // Select resets low so a select already low must first rise
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_m <= 1'b0;
      sel_s <= 1'b0;
      sel_d <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
      wp_m <= 1'b1;
      wp_s <= 1'b1;
    end
    else
    begin
      sel_m <= link.sel_n;
      sel_s <= sel_m;
      sel_d <= sel_s;
      sclk_m <= link.sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      mosi_m <= link.mosi;
      mosi_s <= mosi_m;
      wp_m <= link.wp_n;
      wp_s <= wp_m;
    end
  end

  // ----------------------------------------
  // Edge events and shared state
  // ----------------------------------------
  logic frame_start; // Select fell
  logic frame_end; // Select rose
  logic sclk_rise; // Sampling edge while selected
  logic sclk_fall; // Driving edge while selected
  esp_dev_state_e state; // Frame decoder state
  logic [2:0] bit_cnt; // Bits of current byte
  logic [6:0] in_sh; // Input shift, MSB first
  logic [7:0] in_byte; // Byte completed this edge
  logic [7:0] opcode; // Decoded instruction
  logic [7:0] pending; // Status byte awaiting commit
  logic write_latch_flag; // Write enable latch
  logic busy; // Self-timed cycle running
  logic status_cycle; // Running cycle is a status write
  logic [31:0] cyc_cnt; // Cycle timer
  logic lock; // Nonvolatile lock bit
  logic [1:0] prot_sel; // Nonvolatile protect selects
  logic hw_mode; // Hardware protected, live
  logic [7:0] status_now; // Live status byte
  logic do_set, do_clear, do_status_write_cmd; // Frame-end actions
  logic arr_ok; // Array write may start

  assign frame_start = sel_d & ~sel_s;
  assign frame_end = sel_s & ~sel_d;
  assign sclk_rise = ~sel_s & sclk_s & ~sclk_d;
  assign sclk_fall = ~sel_s & ~sclk_s & sclk_d;
  assign in_byte = {in_sh, mosi_s};
  assign hw_mode = lock & ~wp_s;

  // Reserved bits always zero, layout fixed
  assign status_now = {lock, 3'h0, prot_sel, write_latch_flag, busy};

  // Latch instructions act only once select rises cleanly after 8 bits
  assign do_set = frame_end && state == DEV_WAIT_END && opcode == OP_LATCH_SET;
  assign do_clear = frame_end && state == DEV_WAIT_END && opcode == OP_LATCH_CLEAR;
  assign do_status_write_cmd = frame_end && state == DEV_WR_DONE;

  // Array write gated by latch, busy and current selects
  assign arr_ok = write_latch_flag && !busy && !esp_in_region(prot_sel, array_wr_addr);

  // ----------------------------------------
  // Frame decoder
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= DEV_IDLE;
      bit_cnt <= 3'h0;
      in_sh <= 7'h00;
      opcode <= 8'h00;
      pending <= 8'h00;
    end
    else if (frame_end)
    begin
      state <= DEV_IDLE; // Any deselect ends the frame
    end
    else if (frame_start)
    begin
      state <= DEV_OPCODE;
      bit_cnt <= 3'h0;
    end
    else if (sclk_rise)
    begin
      in_sh <= in_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      case (state)
        DEV_OPCODE:
        begin
          if (bit_cnt == 3'h7)
          begin
            opcode <= in_byte;
            case (in_byte)
              OP_LATCH_SET, OP_LATCH_CLEAR:
                state <= busy ? DEV_IGNORE : DEV_WAIT_END;
              OP_STATUS_READ:
                state <= DEV_STATUS_OUT;
              OP_STATUS_WRITE:
                state <= (write_latch_flag && !busy && !hw_mode) ? DEV_WR_DATA : DEV_IGNORE;
              default:
                state <= DEV_IGNORE; // Unknown opcode deselects
            endcase
          end
        end
        DEV_WR_DATA:
        begin
          if (bit_cnt == 3'h7)
          begin
            pending <= in_byte;
            state <= DEV_WR_DONE;
          end
        end
        DEV_WAIT_END, DEV_WR_DONE:
          state <= DEV_IGNORE; // Extra clock: not a whole instruction
        default:
          state <= state; // Idle, status out, ignore: no change
      endcase
    end
  end

  // ----------------------------------------
  // Status output shifter
  // ----------------------------------------
  logic [2:0] out_cnt; // Bit position within output byte
  logic [6:0] out_sh; // Remaining bits of the byte

  // Each byte snapshots live status, so busy polling sees updates
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_cnt <= 3'h0;
      out_sh <= 7'h00;
      link.miso <= 1'b1;
      link.miso_oe <= 1'b0;
    end
    else
    begin
      link.miso_oe <= state == DEV_STATUS_OUT && !sel_s;
      if (frame_start)
      begin
        out_cnt <= 3'h0;
      end
      else if (sclk_fall && state == DEV_STATUS_OUT)
      begin
        out_cnt <= out_cnt + 3'h1;
        if (out_cnt == 3'h0)
        begin
          link.miso <= status_now[7];
          out_sh <= status_now[6:0];
        end
        else
        begin
          link.miso <= out_sh[6];
          out_sh <= {out_sh[5:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // Self-timed cycle
  // ----------------------------------------
  logic cyc_done; // Last clock of a cycle
  assign cyc_done = busy && cyc_cnt == 32'(CYCLE_LEN - 1);

  // Status and array writes share one timer
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      status_cycle <= 1'b0;
      cyc_cnt <= 32'h0;
    end
    else if (do_status_write_cmd || (array_wr_req && arr_ok))
    begin
      busy <= 1'b1;
      status_cycle <= do_status_write_cmd;
      cyc_cnt <= 32'h0;
    end
    else if (cyc_done)
    begin
      busy <= 1'b0;
    end
    else if (busy)
    begin
      cyc_cnt <= cyc_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // Write enable latch
  // ----------------------------------------
  // Latch instructions are refused while busy, so set never meets cycle end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      write_latch_flag <= 1'b0;
    else if (do_set)
      write_latch_flag <= 1'b1;
    else if (do_clear || cyc_done)
      write_latch_flag <= 1'b0;
  end

  // ----------------------------------------
  // Nonvolatile bits
  // ----------------------------------------
  // No reset here: these survive power-on reset, nv_load sets delivery state
  always_ff @(posedge core_clk)
  begin
    if (nv_load)
    begin
      {lock, prot_sel} <= NV_DELIVERY;
    end
    else if (cyc_done && status_cycle)
    begin
      lock <= pending[LOCK_POS];
      prot_sel <= {pending[SEL_HI_POS], pending[SEL_LO_POS]};
    end
  end

  // ----------------------------------------
  // User-side outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      array_wr_ack <= 1'b0;
      array_wr_nak <= 1'b0;
      protection_status <= 8'h00;
      hard_protect_mode <= 1'b0;
      soft_protect_mode <= 1'b1;
    end
    else
    begin
      array_wr_ack <= array_wr_req && arr_ok && !do_status_write_cmd;
      array_wr_nak <= array_wr_req && !(arr_ok && !do_status_write_cmd);
      protection_status <= status_now;
      hard_protect_mode <= hw_mode;
      soft_protect_mode <= ~hw_mode;
    end
  end

endmodule : esp_device

// [rtl/esp_host.sv]
module esp_host #(
  parameter int HALF_LEN = esp_pkg::SCLK_HALF_CLKS // Link clock half period in core clocks
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  esp_link_if.host link
);
  import esp_pkg::*;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  esp_host_state_e state; // Frame sequencer state
  logic [15:0] tx_sh; // Opcode then data, MSB first
  logic [7:0] rx_byte; // Last byte shifted in
  logic [4:0] bit_cnt; // Bits sent this frame
  logic [4:0] bit_total; // 8 or 16 bits per frame
  logic [31:0] div_cnt; // Half-period divider
  logic tick; // Half-period enable pulse
  logic wp_level; // Level driven on write-protect pin
  logic miso_m, miso_s; // Data-in synchroniser
  logic start; // Command accepted this cycle

  assign tick = state != H_IDLE && div_cnt == 32'(HALF_LEN - 1);
  assign start = reg_wr && reg_addr == HOST_CMD_ADDR && state == H_IDLE;

  // ----------------------------------------
  // Data-in synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      miso_m <= 1'b1;
      miso_s <= 1'b1;
    end
    else
    begin
      miso_m <= link.miso_line;
      miso_s <= miso_m;
    end
  end

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 32'h0;
    else if (state == H_IDLE || tick)
      div_cnt <= 32'h0;
    else
      div_cnt <= div_cnt + 32'h1;
  end

  // ----------------------------------------
  // Frame sequencer, mode 0
  // ----------------------------------------
  // Select rises one half period after the last fall, before any further rise
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= H_IDLE;
      tx_sh <= 16'h0000;
      rx_byte <= 8'h00;
      bit_cnt <= 5'h00;
      bit_total <= 5'h08;
      link.sel_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
    end
    else if (start)
    begin
      state <= H_SETUP;
      link.sel_n <= 1'b0;
      tx_sh <= reg_wdata[7:0] == OP_STATUS_WRITE ? {reg_wdata[7:0], reg_wdata[15:8]}
                                                 : {reg_wdata[7:0], 8'h00};
      bit_total <= (reg_wdata[7:0] == OP_STATUS_WRITE || reg_wdata[7:0] == OP_STATUS_READ) ? 5'h10 : 5'h08;
      bit_cnt <= 5'h00;
    end
    else if (tick)
    begin
      case (state)
        H_SETUP, H_LOW:
        begin
          if (state == H_SETUP)
          begin
            link.mosi <= tx_sh[15];
            tx_sh <= {tx_sh[14:0], 1'b0};
            state <= H_LOW;
          end
          else
          begin
            link.sclk <= 1'b1;
            state <= H_HIGH;
          end
        end
        H_HIGH:
        begin
          rx_byte <= {rx_byte[6:0], miso_s};
          link.sclk <= 1'b0;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == bit_total - 5'h01)
            state <= H_END;
          else
          begin
            link.mosi <= tx_sh[15];
            tx_sh <= {tx_sh[14:0], 1'b0};
            state <= H_LOW;
          end
        end
        H_END:
        begin
          link.sel_n <= 1'b1;
          state <= H_GAP;
        end
        default:
          state <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_level <= 1'b1;
      link.wp_n <= 1'b1;
    end
    else
    begin
      if (reg_wr && reg_addr == HOST_WP_ADDR)
        wp_level <= reg_wdata[0];
      link.wp_n <= wp_level;
    end
  end

  // Read data stands the cycle after the strobe only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd && reg_addr == HOST_STAT_ADDR)
      reg_rdata <= {15'h0, wp_level, rx_byte, 7'h00, state != H_IDLE};
    else if (reg_rd && reg_addr == HOST_WP_ADDR)
      reg_rdata <= {31'h0, wp_level};
    else
      reg_rdata <= 32'h0;
  end

endmodule : esp_host

// [rtl/esp_link_if.sv]
interface esp_link_if;
  logic sel_n; // Chip select, active low
  logic sclk; // Serial clock
  logic mosi; // Data into the device
  logic wp_n; // Write protect, active low
  logic miso; // Data out of the device
  logic miso_oe; // Device drives the data-out line
  logic miso_line; // Resolved line, pulled high when undriven

  assign miso_line = miso_oe ? miso : 1'b1;

  modport device (input sel_n, input sclk, input mosi, input wp_n, output miso, output miso_oe);
  modport host (output sel_n, output sclk, output mosi, output wp_n, input miso_line);
endinterface : esp_link_if

// [rtl/esp_pkg.sv]
package esp_pkg;

  // ----------------------------------------
  // Instruction opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_LATCH_SET = 8'h06; // Sets write latch
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04; // Clears write latch
  localparam logic [7:0] OP_STATUS_READ = 8'h05; // Status read
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // Status write

  // ----------------------------------------
  // Status byte layout
  // ----------------------------------------
  localparam int LOCK_POS = 7; // Status lock bit
  localparam int SEL_HI_POS = 3; // Protect select, high
  localparam int SEL_LO_POS = 2; // Protect select, low
  localparam int LATCH_POS = 1; // Write latch flag
  localparam int ACTIVE_POS = 0; // Cycle active flag
  localparam logic [2:0] NV_DELIVERY = 3'h0; // Lock and selects as delivered

  // ----------------------------------------
  // Array geometry and protected regions
  // ----------------------------------------
  localparam int ADDR_W = 15; // Array address width
  localparam logic [14:0] QUARTER_BASE = 15'h6000; // Upper quarter start
  localparam logic [14:0] HALF_BASE = 15'h4000; // Upper half start

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8; // Core clock period
  localparam int CYCLE_TIME_NS = 40000; // Self-timed cycle length, plain default
  localparam int CYCLE_CLKS = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS = 40; // Half period of the generated link clock
  localparam int SCLK_HALF_CLKS = SCLK_HALF_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Controller register map
  // ----------------------------------------
  localparam logic [3:0] HOST_CMD_ADDR = 4'h0; // W: [7:0] opcode, [15:8] data
  localparam logic [3:0] HOST_STAT_ADDR = 4'h1; // R: [0] busy, [15:8] rx byte, [16] wp
  localparam logic [3:0] HOST_WP_ADDR = 4'h2; // RW: [0] write-protect pin level

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum {DEV_IDLE, DEV_OPCODE, DEV_WAIT_END, DEV_STATUS_OUT, DEV_WR_DATA, DEV_WR_DONE,
                DEV_IGNORE} esp_dev_state_e;
  typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_GAP} esp_host_state_e;

  // Protected region decode, used for array write checks
  function automatic logic esp_in_region(input logic [1:0] sel, input logic [14:0] addr);
    case (sel)
      2'h1: esp_in_region = (addr >= QUARTER_BASE);
      2'h2: esp_in_region = (addr >= HALF_BASE);
      2'h3: esp_in_region = 1'b1;
      default: esp_in_region = 1'b0;
    endcase
  endfunction : esp_in_region

endpackage : esp_pkg

// [sim/esp_link_asserts.sv]
// ----------------------------------------
// Link protocol checker
// ----------------------------------------
module esp_link_asserts #(
  parameter int HALF_LEN = 5 // Link clock half period in core clocks
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] rise_cnt; // Link rises in this frame, modulo eight
  logic [7:0] high_cnt; // Core clocks spent with link clock high

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Rise count clears while deselected, so frame ends land on zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rise_cnt <= 3'h0;
    else if (sel_n)
      rise_cnt <= 3'h0;
    else if ($rose(sclk))
      rise_cnt <= rise_cnt + 3'h1;
  end

  // Length of each high phase of the link clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      high_cnt <= 8'h00;
    else if (sclk)
      high_cnt <= high_cnt + 8'h01;
    else
      high_cnt <= 8'h00;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_idle_clk_low: assert property (sel_n |-> !sclk)
    else $error("link clock high while deselected");
  a_half_period: assert property ($fell(sclk) |-> int'(high_cnt) == HALF_LEN)
    else $error("link clock high phase has wrong length");
  a_byte_frame_end: assert property ($rose(sel_n) |-> rise_cnt == 3'h0)
    else $error("frame ended off a byte boundary");
  a_oe_in_frame: assert property ($rose(miso_oe) |-> !sel_n && rise_cnt == 3'h0)
    else $error("data out driven outside a whole opcode");
  a_oe_release: assert property ($rose(sel_n) |-> ##[1:6] !miso_oe)
    else $error("data out still driven after deselect");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in moved while link clock high");
  a_miso_hold: assert property (miso_oe && $past(miso_oe) && sclk && $past(sclk) |-> $stable(miso))
    else $error("data out moved while link clock high");
  a_select_lead: assert property ($fell(sel_n) |-> !sclk [*8])
    else $error("link clock rose too soon after select");

endmodule : esp_link_asserts

// [sim/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import esp_pkg::*;

  // ----------------------------------------
  // Signals and expected results
  // ----------------------------------------
  localparam int CYC = 400; // Short cycle, still outlasts one status read
  typedef struct packed {logic [7:0] op; logic [7:0] dat; logic wp; logic [7:0] st; logic hp;} esp_row_s;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic nv_load = 1'h1; // Delivery load, held through reset
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic arr_req = 1'h0;
  logic [14:0] arr_addr = 15'h0;
  logic arr_ack, arr_nak, hard_pm, soft_pm;
  logic [7:0] pstat; // Status at the device port
  logic [7:0] st; // Status read over the link
  int fails = 0;
  int n_tests = 0;
  logic [14:0] lo [4] = '{15'h0, 15'h5FFF, 15'h3FFF, 15'h0}; // Just below the quarter and half regions; zero for none and whole
  logic [14:0] hi [4] = '{15'h7FFF, 15'h6000, 15'h4000, 15'h7FFF}; // First protected place for quarter and half; top address for none and whole
  // Opcode, data, pin level, status after, hardware mode after
  esp_row_s rows [15] = '{
    '{8'h06, 8'h00, 1'h1, 8'h02, 1'h0},
    '{8'h04, 8'h00, 1'h1, 8'h00, 1'h0},
    '{8'h01, 8'h8C, 1'h1, 8'h00, 1'h0},
    '{8'h06, 8'h00, 1'h0, 8'h02, 1'h0},
    '{8'h01, 8'hFF, 1'h0, 8'h8C, 1'h1},
    '{8'h06, 8'h00, 1'h0, 8'h8E, 1'h1},
    '{8'h01, 8'h00, 1'h0, 8'h8E, 1'h1},
    '{8'h01, 8'h04, 1'h1, 8'h04, 1'h0},
    '{8'h06, 8'h00, 1'h1, 8'h06, 1'h0},
    '{8'h01, 8'h80, 1'h1, 8'h80, 1'h0},
    '{8'h06, 8'h00, 1'h0, 8'h82, 1'h1},
    '{8'h04, 8'h00, 1'h0, 8'h80, 1'h1},
    '{8'h06, 8'h00, 1'h1, 8'h82, 1'h0},
    '{8'hAA, 8'h00, 1'h1, 8'h82, 1'h0},
    '{8'h01, 8'h0B, 1'h1, 8'h08, 1'h0}
  };

  // ----------------------------------------
  // Clock, link and both ends
  // ----------------------------------------
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  esp_link_if link ();
  esp_device #(.CYCLE_LEN(CYC)) esp_device_inst (.core_clk(core_clk), .rst_n(rst_n), .nv_load(nv_load),
    .link(link), .array_wr_req(arr_req), .array_wr_addr(arr_addr), .array_wr_ack(arr_ack),
    .array_wr_nak(arr_nak), .protection_status(pstat), .hard_protect_mode(hard_pm), .soft_protect_mode(soft_pm));
  esp_host esp_host_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
  esp_link_asserts #(.HALF_LEN(SCLK_HALF_CLKS)) esp_link_asserts_inst (.core_clk(core_clk), .rst_n(rst_n),
    .sel_n(link.sel_n), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test;
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // A bound ran out: count it and stop
  task automatic hang;
    fails++;
    finish_test();
  endtask : hang

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : bus_rd

  // One instruction frame, then wait for the sequencer to go idle
  task automatic send(input logic [7:0] op, input logic [7:0] dat);
    logic [31:0] d;
    int i;
    bus_wr(HOST_CMD_ADDR, {16'h0, dat, op});
    for (i = 0; i < 200; i++)
    begin
      bus_rd(HOST_STAT_ADDR, d);
      if (d[0] === 1'h0)
        break;
    end
    if (i == 200)
      hang();
  endtask : send

  task automatic rd_status(output logic [7:0] s);
    logic [31:0] d;
    send(OP_STATUS_READ, 8'h00);
    bus_rd(HOST_STAT_ADDR, d);
    s = d[15:8];
  endtask : rd_status

  // Poll the busy flag over the link before anything new
  task automatic settle(output logic [7:0] s);
    int i;
    for (i = 0; i < 20; i++)
    begin
      rd_status(s);
      if (s[ACTIVE_POS] === 1'h0)
        break;
    end
    if (i == 20)
      hang();
  endtask : settle

  // Array write request; answer shows in the next cycle
  task automatic arr(input logic [14:0] a, input logic ok);
    @(posedge core_clk);
    arr_req <= 1'h1;
    arr_addr <= a;
    @(posedge core_clk);
    arr_req <= 1'h0;
    #1;
    chk("array ack", {7'h0, ok}, {7'h0, arr_ack});
    chk("array nak", {7'h0, !ok}, {7'h0, arr_nak});
  endtask : arr

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] d;
    int s;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    nv_load <= 1'h0;
    rd_status(st);
    chk("delivery status", 8'h00, st);
    bus_rd(4'hF, d);
    chk("unmapped read", 8'h00, {7'h0, |d});
    foreach (rows[k])
    begin
      bus_wr(HOST_WP_ADDR, {31'h0, rows[k].wp});
      send(rows[k].op, rows[k].dat);
      settle(st);
      chk("row status", rows[k].st, st);
      chk("row status port", rows[k].st, pstat);
      chk("row hard mode", {7'h0, rows[k].hp}, {7'h0, hard_pm});
      chk("row soft mode", {7'h0, ~rows[k].hp}, {7'h0, soft_pm});
    end
    // Pin level register and its copy in the status word
    bus_wr(HOST_WP_ADDR, 32'h0);
    bus_rd(HOST_WP_ADDR, d);
    chk("wp readback", 8'h00, d[7:0]);
    bus_rd(HOST_STAT_ADDR, d);
    chk("wp in status", 8'h00, {7'h0, d[16]});
    bus_wr(HOST_WP_ADDR, 32'h1);
    // Read in mid-cycle: busy and latch up, old selects still shown
    send(OP_LATCH_SET, 8'h00);
    send(OP_STATUS_WRITE, 8'h04);
    rd_status(st);
    chk("status in cycle", 8'h0B, st);
    chk("status port in cycle", 8'h0B, pstat);
    settle(st);
    chk("status after cycle", 8'h04, st);
    arr(15'h0000, 1'h0);
    // Every select encoding: both sides of the quarter and half boundaries, both ends for none and whole
    for (s = 0; s < 4; s++)
    begin
      send(OP_LATCH_SET, 8'h00);
      send(OP_STATUS_WRITE, {4'h0, s[1:0], 2'h0});
      settle(st);
      send(OP_LATCH_SET, 8'h00);
      arr(lo[s], s != 3);
      settle(st);
      send(OP_LATCH_SET, 8'h00);
      arr(hi[s], s == 0);
      settle(st);
      chk("array status", {4'h0, s[1:0], s != 0, 1'h0}, st);
    end
    // Mid-run reset keeps only the nonvolatile bits
    @(posedge core_clk);
    rst_n <= 1'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    rd_status(st);
    chk("status after reset", 8'h0C, st);
    finish_test();
  end

endmodule : tb_top
